// *** phs_pkg.sv ***
// package of register map, field positions and timing counts for the block
package phs_pkg;
	// register indexes; each register takes one aligned word
	localparam logic [11:0] HOLDOVER_CONTROL_IDX = 12'h001d;
	localparam logic [11:0] PLL_STATUS_READBACK_IDX = 12'h001f;
	localparam logic [11:0] STATUS_DISABLE_IDX = 12'h0020;
	// register byte addresses, four times the index
	localparam logic [11:0] HOLDOVER_CONTROL_ADDR =
		12'(HOLDOVER_CONTROL_IDX * 4);
	localparam logic [11:0] PLL_STATUS_READBACK_ADDR =
		12'(PLL_STATUS_READBACK_IDX * 4);
	localparam logic [11:0] STATUS_DISABLE_ADDR = 12'(STATUS_DISABLE_IDX * 4);
	// holdover control fields
	localparam int HC_EN_LO_BIT = 0;
	localparam int HC_EXT_SEL_BIT = 1;
	localparam int HC_EN_HI_BIT = 2;
	localparam int HC_LDCMP_BIT = 3;
	localparam logic [7:0] HC_RESET = 8'h00;
	localparam logic [7:0] HC_WR_MASK = 8'h0f;
	// status readback fields
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_PRI_FREQ_BIT = 1;
	localparam int ST_SEC_FREQ_BIT = 2;
	localparam int ST_VCO_FREQ_BIT = 3;
	localparam int ST_SEC_SEL_BIT = 4;
	localparam int ST_HOLD_BIT = 5;
	localparam int ST_CAL_DONE_BIT = 6;
	// own status disable register field
	localparam int SD_DISABLE_BIT = 0;
	// hold entry filter length in clock cycles
	localparam int HOLD_ENTRY_NS = 100;
	localparam int CLK_PERIOD_NS = 50;
	localparam int HOLD_ENTRY_CYC = (HOLD_ENTRY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// holdover controller states, gray coded
	typedef enum logic [1:0] {
		PHS_IDLE = 2'b00,
		PHS_ARMED = 2'b01,
		PHS_HOLD = 2'b11
	} phs_state_t;
endpackage

// *** phs_regs.sv ***
// holdover control and pll status register bank with apb slave
// What this block does
// - bit 1 set: hold pin decides holdover; clear: automatic circuit decides
// - external select turns off the automatic holdover decision entirely
// - holdover works only when enable bits 0 and 2 are both set
// - status bit 6 shows vco calibration finished; writes ignored
// - status bit 5 shows actual holdover state, not the enable setting
// - status bit 4 is 1 when secondary reference feeds the pll
// - status bit 3 is 1 when vco frequency is above threshold
// - status bit 2 is 1 when secondary reference above its threshold
// - bit 2 is second holdover enable, resets to 0
// - status bit 0 is 1 when the digital lock detector sees lock
// - lock pin comparator off: automatic controller treats lock pin high
`timescale 1ns/10ps
module phs_regs #(
	parameter int HOLD_CYC = phs_pkg::HOLD_ENTRY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hold_select_pin,
	input wire logic lock_detect_pin,
	input wire logic vco_cal_done,
	input wire logic digital_lock,
	input wire logic ref_lost,
	input wire logic secondary_ref_selected,
	input wire logic vco_above_threshold,
	input wire logic secondary_ref_above_threshold,
	input wire logic primary_ref_above_threshold,
	output logic holdover_active
);
	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [7:0] ctrl;
		logic stat_dis;
		phs_pkg::phs_state_t st;
		logic [7:0] cnt;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic hold;
	} phs_st_t;
	phs_st_t r_q;
	phs_st_t r_d;
	logic [8:0] pins;
	logic hold_pin_s;
	logic lock_pin_s;
	logic cal_s;
	logic lock_s;
	logic lost_s;
	logic sel2_s;
	logic vco_s;
	logic ref2f_s;
	logic ref1f_s;
	logic en_both;
	logic lock_ok;
	logic access;
	logic [7:0] status;

	// all pin level inputs pass two flip-flops
	phs_sync #(.WIDTH(9)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({hold_select_pin, lock_detect_pin, vco_cal_done,
			digital_lock, ref_lost, secondary_ref_selected,
			vco_above_threshold, secondary_ref_above_threshold,
			primary_ref_above_threshold}),
		.sync_out(pins)
	);
	assign {hold_pin_s, lock_pin_s, cal_s, lock_s, lost_s, sel2_s, vco_s,
		ref2f_s, ref1f_s} = pins;

	// address decode shared by read and write paths
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		if (a == phs_pkg::HOLDOVER_CONTROL_ADDR) begin
			reg_sel = 2'h1;
		end else if (a == phs_pkg::PLL_STATUS_READBACK_ADDR) begin
			reg_sel = 2'h2;
		end else if (a == phs_pkg::STATUS_DISABLE_ADDR) begin
			reg_sel = 2'h3;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// status word assembly
	assign en_both = r_q.ctrl[phs_pkg::HC_EN_LO_BIT]
		& r_q.ctrl[phs_pkg::HC_EN_HI_BIT];
	// comparator off: lock pin counts as high
	assign lock_ok = r_q.ctrl[phs_pkg::HC_LDCMP_BIT] ? lock_pin_s
		: 1'b1;
	assign access = psel & penable & ~r_q.ready;

	always_comb begin
		status = 8'h00;
		status[phs_pkg::ST_CAL_DONE_BIT] = cal_s;
		status[phs_pkg::ST_HOLD_BIT] = r_q.hold;
		status[phs_pkg::ST_SEC_SEL_BIT] = sel2_s;
		status[phs_pkg::ST_VCO_FREQ_BIT] = vco_s;
		status[phs_pkg::ST_SEC_FREQ_BIT] = ref2f_s;
		status[phs_pkg::ST_PRI_FREQ_BIT] = ref1f_s;
		status[phs_pkg::ST_LOCK_BIT] = lock_s;
	end

	////////////////////////////////////////////////////////////////////////
	// next state: bus slave and holdover controller
	always_comb begin
		r_d = r_q;
		r_d.ready = 1'b0;
		r_d.err = 1'b0;
		// apb answers one cycle into the access phase
		if (access) begin
			r_d.ready = 1'b1;
			r_d.rdata = 32'h0000_0000;
			case (reg_sel(paddr))
				2'h1: begin
					r_d.rdata = {24'h00_0000, r_q.ctrl};
					if (pwrite) begin
						r_d.ctrl = pwdata[7:0] & phs_pkg::HC_WR_MASK;
					end
				end
				2'h2: begin
					// read-only, writes have no effect
					if (!r_q.stat_dis) begin
						r_d.rdata = {24'h00_0000, status};
					end
				end
				2'h3: begin
					r_d.rdata = {31'h0000_0000, r_q.stat_dis};
					if (pwrite) begin
						r_d.stat_dis = pwdata[phs_pkg::SD_DISABLE_BIT];
					end
				end
				default: begin
					r_d.err = 1'b1;
				end
			endcase
		end
		// holdover controller
		if (!en_both) begin
			r_d.st = phs_pkg::PHS_IDLE;
			r_d.cnt = 8'h00;
		end else if (r_q.ctrl[phs_pkg::HC_EXT_SEL_BIT]) begin
			// pin alone governs; automatic path bypassed
			r_d.st = hold_pin_s ? phs_pkg::PHS_HOLD
				: phs_pkg::PHS_IDLE;
			r_d.cnt = 8'h00;
		end else begin
			case (r_q.st)
				phs_pkg::PHS_IDLE: begin
					r_d.cnt = 8'h00;
					if (lost_s && lock_ok) begin
						r_d.st = phs_pkg::PHS_ARMED;
					end
				end
				phs_pkg::PHS_ARMED: begin
					if (!lost_s) begin
						r_d.st = phs_pkg::PHS_IDLE;
					end else if (r_q.cnt >= 8'(HOLD_CYC - 1)) begin
						r_d.st = phs_pkg::PHS_HOLD;
					end else begin
						r_d.cnt = r_q.cnt + 8'h01;
					end
				end
				phs_pkg::PHS_HOLD: begin
					if (!lost_s) begin
						r_d.st = phs_pkg::PHS_IDLE;
					end
				end
				default: begin
					r_d.st = phs_pkg::PHS_IDLE;
				end
			endcase
		end
		r_d.hold = (r_d.st == phs_pkg::PHS_HOLD) && en_both;
	end

	// register all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata = r_q.rdata;
	assign pready = r_q.ready;
	assign pslverr = r_q.err;
	assign holdover_active = r_q.hold;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ext_hold;
		en_both && r_q.ctrl[phs_pkg::HC_EXT_SEL_BIT] && hold_pin_s;
	endsequence
	// first step of automatic entry: idle, enabled, reference lost, lock ok
	sequence s_auto_arm;
		r_q.st == phs_pkg::PHS_IDLE && en_both && lost_s && lock_ok
			&& !r_q.ctrl[phs_pkg::HC_EXT_SEL_BIT];
	endsequence

	a_ext_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_ext_hold |=> holdover_active)
		else $error("external hold pin not followed");
	a_ext_no_auto: assert property (@(posedge pclk) disable iff (!presetn)
		en_both && r_q.ctrl[phs_pkg::HC_EXT_SEL_BIT] && !hold_pin_s
		|=> !holdover_active)
		else $error("automatic holdover active in external mode");
	a_hold_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
		holdover_active |-> $past(en_both))
		else $error("holdover without both enables");
	a_cal_readback: assert property (@(posedge pclk) disable iff (!presetn)
		access && reg_sel(paddr) == 2'h2 && !r_q.stat_dis
		|=> prdata[phs_pkg::ST_CAL_DONE_BIT] == $past(cal_s))
		else $error("calibration bit readback wrong");
	a_hold_readback: assert property (@(posedge pclk) disable iff (!presetn)
		access && reg_sel(paddr) == 2'h2 && !r_q.stat_dis
		|=> prdata[phs_pkg::ST_HOLD_BIT] == $past(holdover_active))
		else $error("holdover bit readback wrong");
	a_lock_readback: assert property (@(posedge pclk) disable iff (!presetn)
		access && reg_sel(paddr) == 2'h2 && !r_q.stat_dis
		|=> prdata[phs_pkg::ST_LOCK_BIT] == $past(lock_s))
		else $error("lock bit readback wrong");
	a_ref_readback: assert property (@(posedge pclk) disable iff (!presetn)
		access && reg_sel(paddr) == 2'h2 && !r_q.stat_dis
		|=> prdata[4:2] == $past({sel2_s, vco_s, ref2f_s}))
		else $error("reference and vco bits readback wrong");
	a_disable_drop: assert property (@(posedge pclk) disable iff (!presetn)
		!en_both |=> !holdover_active)
		else $error("holdover stays after disable");
	a_auto_entry: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.st == phs_pkg::PHS_IDLE && en_both && lost_s && !lock_ok
		&& !r_q.ctrl[phs_pkg::HC_EXT_SEL_BIT]
		|=> r_q.st == phs_pkg::PHS_IDLE)
		else $error("armed without lock pin");
	a_auto_arm: assert property (@(posedge pclk) disable iff (!presetn)
		s_auto_arm |=> r_q.st == phs_pkg::PHS_ARMED)
		else $error("automatic controller did not start entry");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		access |=> pready ##1 !pready)
		else $error("apb answer not single cycle");
endmodule

// *** phs_sync.sv ***
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module phs_sync #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} phs_sync_st_t;
	phs_sync_st_t s_q;
	phs_sync_st_t s_d;

	// first stage feeds only the second
	always_comb begin
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	// registers both stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule

// *** tb_phs_regs.sv ***
// self-checking testbench for the holdover control and pll status registers
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
	comparisons++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("FAIL %s expected %h seen %h", nm, exp, got); \
	end
module tb_phs_regs;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, rerr;
	logic hold_select_pin, lock_detect_pin, ref_lost, holdover_active;
	logic [6:0] st_in; // status sources, index is the status bit
	int error_cnt, comparisons;
	localparam logic [11:0] HC = phs_pkg::HOLDOVER_CONTROL_ADDR;
	localparam logic [11:0] ST = phs_pkg::PLL_STATUS_READBACK_ADDR;
	localparam logic [11:0] SD = phs_pkg::STATUS_DISABLE_ADDR;
	////////////////////////////////////////////////////////////////////////
	// device under test
	phs_regs i_phs_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hold_select_pin(hold_select_pin), .lock_detect_pin(lock_detect_pin),
		.vco_cal_done(st_in[6]), .digital_lock(st_in[0]), .ref_lost(ref_lost),
		.secondary_ref_selected(st_in[4]), .vco_above_threshold(st_in[3]),
		.secondary_ref_above_threshold(st_in[2]),
		.primary_ref_above_threshold(st_in[1]),
		.holdover_active(holdover_active));
	////////////////////////////////////////////////////////////////////////
	// clock generator
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1)
			error_cnt++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read a register and compare with the expected word
	task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, exp, rdat)
	endtask
	// let pin levels pass the synchronisers and the controller
	task wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// verdict and end of run
	task summarize;
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
	// main test sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{hold_select_pin, lock_detect_pin, ref_lost, st_in} = '0;
		error_cnt = 0;
		comparisons = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(HC, 32'h0000_0000, "control reset");
		rd(ST, 32'h0000_0000, "status reset");
		apb(1'b1, HC, 32'hffff_ffff);
		rd(HC, 32'h0000_000f, "control write");
		apb(1'b1, HC, 32'h0000_0000);
		// each status source in turn, bit 5 is the holdover state
		for (int i = 0; i < 7; i++) begin
			if (i != 5) begin
				st_in <= 7'h01 << i;
				wt(4);
				rd(ST, 32'h0000_0001 << i, "status bit");
			end
		end
		st_in <= 7'h5f;
		apb(1'b1, ST, 32'h0000_0000);
		`CHK("status write no error", 1'b0, rerr)
		rd(ST, 32'h0000_005f, "status write ignored");
		apb(1'b1, SD, 32'h0000_0001);
		rd(ST, 32'h0000_0000, "status disabled");
		apb(1'b1, SD, 32'h0000_0000);
		// calibration finished before any holdover is enabled
		st_in <= 7'h40;
		apb(1'b0, 12'h0f00, 32'h0000_0000);
		`CHK("unmapped error", 1'b1, rerr)
		`CHK("unmapped data", 32'h0000_0000, rdat)
		// external mode: lost reference alone must not hold
		ref_lost <= 1'b1;
		apb(1'b1, HC, 32'h0000_0007);
		wt(10);
		`CHK("ext no pin", 1'b0, holdover_active)
		rd(ST, 32'h0000_0040, "status not holding");
		hold_select_pin <= 1'b1;
		wt(6);
		`CHK("ext pin hold", 1'b1, holdover_active)
		rd(ST, 32'h0000_0060, "status holding");
		apb(1'b1, HC, 32'h0000_0003);
		wt(3);
		`CHK("enable2 off", 1'b0, holdover_active)
		hold_select_pin <= 1'b0;
		// automatic mode, comparator off: lock pin taken as high
		apb(1'b1, HC, 32'h0000_0005);
		wt(10);
		`CHK("auto hold", 1'b1, holdover_active)
		apb(1'b1, HC, 32'h0000_0004);
		wt(3);
		`CHK("enable0 off", 1'b0, holdover_active)
		apb(1'b1, HC, 32'h0000_0005);
		wt(10);
		`CHK("auto re-entry", 1'b1, holdover_active)
		ref_lost <= 1'b0;
		wt(6);
		`CHK("auto leave", 1'b0, holdover_active)
		// comparator on: low lock pin blocks automatic holdover
		apb(1'b1, HC, 32'h0000_000d);
		ref_lost <= 1'b1;
		wt(10);
		`CHK("lock pin low", 1'b0, holdover_active)
		lock_detect_pin <= 1'b1;
		wt(10);
		`CHK("lock pin high", 1'b1, holdover_active)
		summarize();
	end
endmodule
